// file: dpbs_cfg.svh
// constants of the banked dual-port memory: widths, depth, reset values
`ifndef DPBS_CFG_SVH
`define DPBS_CFG_SVH
`define DPBS_DATA_W    36
`define DPBS_LANE_W    9
`define DPBS_LANES     4
`define DPBS_BANK_W    6
`define DPBS_WORD_W    12
`define DPBS_ADDR_W    18
`define DPBS_DEPTH     262144
`define DPBS_ADDR_RST  18'h00000
`define DPBS_DATA_RST  36'h000000000
`define DPBS_LANE_RST  4'h0
`define DPBS_ADDR_STEP 18'h00001
`endif

// file: dpbs_pkg.sv
// types and shared helpers of the banked dual-port memory
`include "dpbs_cfg.svh"
package dpbs_pkg;
    typedef logic [`DPBS_ADDR_W-1:0] dpbs_addr_t;
    typedef logic [`DPBS_DATA_W-1:0] dpbs_data_t;
    typedef logic [`DPBS_LANES-1:0]  dpbs_lane_t;
    // address source of one edge, gray order along hold-step-load-reload
    typedef enum logic [1:0] {
        dpbs_src_hold   = 2'h0,
        dpbs_src_step   = 2'h1,
        dpbs_src_load   = 2'h3,
        dpbs_src_reload = 2'h2
    } dpbs_src_t;

    // widen a 4-bit lane mask to one bit per data pin
    function automatic dpbs_data_t dpbs_lane_expand(input dpbs_lane_t m);
        dpbs_data_t r;
        r = '0;
        for (int i = 0; i < `DPBS_LANES; i++) begin
            r[i*`DPBS_LANE_W +: `DPBS_LANE_W] = {`DPBS_LANE_W{m[i]}};
        end
        return r;
    endfunction
endpackage

// file: dpbs_port_ctl.sv
// per-port address counter with load strobe, advance and reload
`timescale 1ns/10ps
`include "dpbs_cfg.svh"
module dpbs_port_ctl (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire dpbs_pkg::dpbs_addr_t ext_addr_in,
    input  wire logic              load_n_in,
    input  wire logic              advance_n_in,
    input  wire logic              reload_n_in,
    output dpbs_pkg::dpbs_addr_t   addr_out
);
    dpbs_pkg::dpbs_src_t  src;
    dpbs_pkg::dpbs_addr_t cnt_reg;
    dpbs_pkg::dpbs_addr_t cnt_next;
    dpbs_pkg::dpbs_addr_t load_reg;
    dpbs_pkg::dpbs_addr_t load_next;

    // reload beats load beats advance; no chip enable takes part
    always_comb begin
        if (!reload_n_in) begin
            src = dpbs_pkg::dpbs_src_reload;
        end else if (!load_n_in) begin
            src = dpbs_pkg::dpbs_src_load;
        end else if (!advance_n_in) begin
            src = dpbs_pkg::dpbs_src_step;
        end else begin
            src = dpbs_pkg::dpbs_src_hold;
        end
    end

    // the counter spans bank and word, so carry out of the word field moves the bank
    always_comb begin
        unique case (src)
            dpbs_pkg::dpbs_src_reload: cnt_next = load_reg;
            dpbs_pkg::dpbs_src_load:   cnt_next = ext_addr_in;
            dpbs_pkg::dpbs_src_step:   cnt_next = cnt_reg + `DPBS_ADDR_STEP;
            dpbs_pkg::dpbs_src_hold:   cnt_next = cnt_reg;
        endcase
        // a strobe refreshes the reload address even alongside a reload
        load_next = !load_n_in ? ext_addr_in : load_reg;
    end

    assign addr_out = cnt_next;

    // reload address is cleared at reset only so that it is never unknown
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cnt_reg  <= `DPBS_ADDR_RST;
            load_reg <= `DPBS_ADDR_RST;
        end else begin
            cnt_reg  <= cnt_next;
            load_reg <= load_next;
        end
    end

    reload_to_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!load_n_in && reload_n_in) ##1 (!reload_n_in && load_n_in)
        |-> addr_out == $past(ext_addr_in, 1))
        else $error("reload did not return the last loaded address");
    step_wraps_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (load_n_in && reload_n_in && !advance_n_in)
        |=> cnt_reg == dpbs_pkg::dpbs_addr_t'($past(cnt_reg) + `DPBS_ADDR_STEP))
        else $error("counter did not advance by one across banks");
    hold_counter_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (load_n_in && reload_n_in && advance_n_in) |=> $stable(cnt_reg))
        else $error("counter moved with advance disabled");
endmodule

// file: dpbs_top.sv
// banked dual-port memory: two synchronous ports sharing 64 banks of 4K x 36
`timescale 1ns/10ps
`include "dpbs_cfg.svh"
module dpbs_top (
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        a_chip_select_active_low_in,
    input  wire logic                        a_chip_select_active_high_in,
    input  wire logic                        a_read_write_select_in,
    input  wire logic                        a_output_enable_n_in,
    input  wire logic [`DPBS_LANES-1:0]      a_byte_lane_enable_n_in,
    input  wire logic [`DPBS_BANK_W-1:0]     a_bank_select_in,
    input  wire logic [`DPBS_WORD_W-1:0]     a_word_addr_in,
    input  wire logic                        a_address_load_strobe_n_in,
    input  wire logic                        a_counter_advance_enable_n_in,
    input  wire logic                        a_counter_reload_n_in,
    input  wire logic                        a_output_latency_select_in,
    input  wire logic [`DPBS_DATA_W-1:0]     a_dq_in,
    output logic      [`DPBS_DATA_W-1:0]     a_dq_out,
    output logic      [`DPBS_DATA_W-1:0]     a_dq_oe_out,
    input  wire logic                        b_chip_select_active_low_in,
    input  wire logic                        b_chip_select_active_high_in,
    input  wire logic                        b_read_write_select_in,
    input  wire logic                        b_output_enable_n_in,
    input  wire logic [`DPBS_LANES-1:0]      b_byte_lane_enable_n_in,
    input  wire logic [`DPBS_BANK_W-1:0]     b_bank_select_in,
    input  wire logic [`DPBS_WORD_W-1:0]     b_word_addr_in,
    input  wire logic                        b_address_load_strobe_n_in,
    input  wire logic                        b_counter_advance_enable_n_in,
    input  wire logic                        b_counter_reload_n_in,
    input  wire logic                        b_output_latency_select_in,
    input  wire logic [`DPBS_DATA_W-1:0]     b_dq_in,
    output logic      [`DPBS_DATA_W-1:0]     b_dq_out,
    output logic      [`DPBS_DATA_W-1:0]     b_dq_oe_out
);
    // per-port views, index 0 is port a and 1 is port b
    logic [1:0]           cs_lo;
    logic [1:0]           cs_hi;
    logic [1:0]           rw;
    logic [1:0]           oe_n;
    logic [1:0]           ads_n;
    logic [1:0]           adv_n;
    logic [1:0]           rld_n;
    logic [1:0]           lat;
    dpbs_pkg::dpbs_lane_t be_n      [2];
    dpbs_pkg::dpbs_addr_t ext_addr  [2];
    dpbs_pkg::dpbs_addr_t addr_used [2];
    dpbs_pkg::dpbs_data_t din       [2];

    // storage and per-port state
    dpbs_pkg::dpbs_data_t mem [0:`DPBS_DEPTH-1];
    logic [1:0]           sel;
    logic                 coll;
    dpbs_pkg::dpbs_data_t wr_mask        [2];
    dpbs_pkg::dpbs_data_t flow_reg       [2];
    dpbs_pkg::dpbs_data_t flow_next      [2];
    dpbs_pkg::dpbs_data_t pipe_reg       [2];
    dpbs_pkg::dpbs_data_t pipe_next      [2];
    dpbs_pkg::dpbs_lane_t flow_lane_reg  [2];
    dpbs_pkg::dpbs_lane_t flow_lane_next [2];
    dpbs_pkg::dpbs_lane_t pipe_lane_reg  [2];
    dpbs_pkg::dpbs_lane_t pipe_lane_next [2];
    dpbs_pkg::dpbs_data_t dq_drv         [2];
    dpbs_pkg::dpbs_data_t dq_en          [2];

    // gather the two pin groups into arrays so one loop serves both ports
    assign cs_lo       = {b_chip_select_active_low_in, a_chip_select_active_low_in};
    assign cs_hi       = {b_chip_select_active_high_in, a_chip_select_active_high_in};
    assign rw          = {b_read_write_select_in, a_read_write_select_in};
    assign oe_n        = {b_output_enable_n_in, a_output_enable_n_in};
    assign ads_n       = {b_address_load_strobe_n_in, a_address_load_strobe_n_in};
    assign adv_n       = {b_counter_advance_enable_n_in, a_counter_advance_enable_n_in};
    assign rld_n       = {b_counter_reload_n_in, a_counter_reload_n_in};
    assign lat         = {b_output_latency_select_in, a_output_latency_select_in};
    assign be_n[0]     = a_byte_lane_enable_n_in;
    assign be_n[1]     = b_byte_lane_enable_n_in;
    assign ext_addr[0] = {a_bank_select_in, a_word_addr_in};
    assign ext_addr[1] = {b_bank_select_in, b_word_addr_in};
    assign din[0]      = a_dq_in;
    assign din[1]      = b_dq_in;

    // one address counter per port; it runs even while the port is deselected
    for (genvar p = 0; p < 2; p++) begin : g_port
        dpbs_port_ctl u_ctl (
            .clk_in       (clk_in),
            .rstn_in      (rstn_in),
            .ext_addr_in  (ext_addr[p]),
            .load_n_in    (ads_n[p]),
            .advance_n_in (adv_n[p]),
            .reload_n_in  (rld_n[p]),
            .addr_out     (addr_used[p])
        );
    end

    // access decode: a port only accesses when both chip selects agree and a lane is on
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            sel[p] = !cs_lo[p] && cs_hi[p] && !(&be_n[p]);
        end
        // same bank on both ports blocks the writes of both ports to save the array; reads still go ahead
        coll = &sel && (addr_used[0][`DPBS_ADDR_W-1:`DPBS_WORD_W] ==
                        addr_used[1][`DPBS_ADDR_W-1:`DPBS_WORD_W]);
        for (int p = 0; p < 2; p++) begin
            wr_mask[p] = '0;
            if (sel[p] && !rw[p] && !coll) begin
                wr_mask[p] = dpbs_pkg::dpbs_lane_expand(~be_n[p]);
            end
        end
    end

    // lane-masked write; an idle port must not write back, or it could undo the other
    // port's write whenever its counter happens to point at the same word
    always_ff @(posedge clk_in) begin
        for (int p = 0; p < 2; p++) begin
            if (wr_mask[p] != '0) begin
                mem[addr_used[p]] <= (mem[addr_used[p]] & ~wr_mask[p]) | (din[p] & wr_mask[p]);
            end
        end
    end

    // read path: flow stage follows the addressing edge, pipe stage adds one cycle
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            // colliding reads still return array contents; those are not trustworthy
            flow_next[p]      = mem[addr_used[p]];
            flow_lane_next[p] = (sel[p] && rw[p]) ? ~be_n[p] : `DPBS_LANE_RST;
            pipe_next[p]      = flow_reg[p];
            pipe_lane_next[p] = flow_lane_reg[p];
        end
    end

    always_ff @(posedge clk_in) begin
        for (int p = 0; p < 2; p++) begin
            if (!rstn_in) begin
                flow_reg[p]      <= `DPBS_DATA_RST;
                pipe_reg[p]      <= `DPBS_DATA_RST;
                flow_lane_reg[p] <= `DPBS_LANE_RST;
                pipe_lane_reg[p] <= `DPBS_LANE_RST;
            end else begin
                flow_reg[p]      <= flow_next[p];
                pipe_reg[p]      <= pipe_next[p];
                flow_lane_reg[p] <= flow_lane_next[p];
                pipe_lane_reg[p] <= pipe_lane_next[p];
            end
        end
    end

    // pin drive: the enable is gated by output enable with no clock in the path
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            dq_drv[p] = lat[p] ? pipe_reg[p] : flow_reg[p];
            dq_en[p]  = dpbs_pkg::dpbs_lane_expand(lat[p] ? pipe_lane_reg[p]
                                                          : flow_lane_reg[p]);
            if (oe_n[p]) begin
                dq_en[p] = '0;
            end
        end
    end

    assign a_dq_out    = dq_drv[0];
    assign a_dq_oe_out = dq_en[0];
    assign b_dq_out    = dq_drv[1];
    assign b_dq_oe_out = dq_en[1];

    // helper: remember the last port-a write so its lanes can be checked next edge
    dpbs_pkg::dpbs_addr_t chk_addr_reg;
    dpbs_pkg::dpbs_data_t chk_data_reg;
    dpbs_pkg::dpbs_data_t chk_mask_reg;
    always_ff @(posedge clk_in) begin
        chk_addr_reg <= addr_used[0];
        chk_data_reg <= din[0];
        chk_mask_reg <= wr_mask[0];
    end

    write_lanes_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $past(rstn_in) && chk_mask_reg != '0
        |-> ((mem[chk_addr_reg] ^ chk_data_reg) & chk_mask_reg) == '0)
        else $error("written lanes do not hold the write data");
    oe_float_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (a_output_enable_n_in |-> a_dq_oe_out == '0) and
        (b_output_enable_n_in |-> b_dq_oe_out == '0))
        else $error("data pins driven while output enable is high");
    read_lanes_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (sel[0] && rw[0] && !lat[0]) ##1 (!oe_n[0] && !lat[0])
        |-> a_dq_oe_out == dpbs_pkg::dpbs_lane_expand(~$past(be_n[0])))
        else $error("read drives a lane other than the enabled ones");
    any_pattern_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (sel[1] && !rw[1] && !coll)
        |-> wr_mask[1] == dpbs_pkg::dpbs_lane_expand(~be_n[1]))
        else $error("lane pattern not honoured on write");
    deselect_float_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!sel[0] && !lat[0]) ##1 !lat[0] |-> a_dq_oe_out == '0 && $past(wr_mask[0]) == '0)
        else $error("deselected port accessed or drove pins");
    bank_clash_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (&sel && ext_addr[0] != ext_addr[1] &&
         addr_used[0][`DPBS_ADDR_W-1:`DPBS_WORD_W] == addr_used[1][`DPBS_ADDR_W-1:`DPBS_WORD_W])
        |-> wr_mask[0] == '0 && wr_mask[1] == '0)
        else $error("write allowed while both ports share a bank");
    pipe_delay_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (lat[1] && sel[1] && rw[1]) ##1 lat[1] ##1 lat[1]
        |-> b_dq_out == $past(flow_next[1], 2))
        else $error("pipelined read not delayed by exactly one cycle");
    flow_direct_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!lat[1] && sel[1] && rw[1]) ##1 !lat[1] |-> b_dq_out == $past(flow_next[1]))
        else $error("flow-through read not present after the addressing edge");
endmodule

// file: dpbs_host.sv
// host controller model that drives one memory port
`timescale 1ns/10ps
module dpbs_host (
    input  wire logic        clk_in,
    output logic             csl_out,
    output logic             csh_out,
    output logic             rw_out,
    output logic             oen_out,
    output logic [3:0]       be_out,
    output logic [5:0]       bank_out,
    output logic [11:0]      word_out,
    output logic             ads_out,
    output logic             adv_out,
    output logic             rel_out,
    output logic             lat_out,
    output logic [35:0]      dq_out
);
    // start deselected with quiet counter controls, outputs enabled, flow-through
    initial begin
        {csl_out, csh_out, rw_out, oen_out, be_out} = 8'hEF;
        {bank_out, word_out} = 18'h00000;
        {ads_out, adv_out, rel_out, lat_out} = 4'hE;
        dq_out = 36'h000000000;
    end

    // one request per call, held until the next call so the rising edge sees it stable
    task automatic drive(input logic [1:0] sel, input logic rw, input logic [3:0] be,
                         input logic [17:0] ad, input logic [35:0] d, input logic [2:0] ctl);
        @(negedge clk_in);
        {csl_out, csh_out} <= sel;
        rw_out <= rw;
        be_out <= be;
        bank_out <= ad[17:12];
        word_out <= ad[11:0];
        {ads_out, adv_out, rel_out} <= ctl;
        // a released data bus must not keep its last value, so invert it
        dq_out <= rw ? ~dq_out : d;
    endtask

    // output enable and latency select, changed off the rising edge
    task automatic mode(input logic oe_n, input logic lat);
        @(negedge clk_in);
        oen_out <= oe_n;
        lat_out <= lat;
    endtask
endmodule

// file: tb.sv
// self-checking bench of the banked dual-port memory, one host model per port
`timescale 1ns/10ps
module tb;
    logic clk_in = 1'b0, rstn_in = 1'b0;
    logic a_chip_select_active_low_in, a_chip_select_active_high_in, a_read_write_select_in;
    logic a_output_enable_n_in, a_address_load_strobe_n_in, a_counter_advance_enable_n_in;
    logic a_counter_reload_n_in, a_output_latency_select_in;
    logic b_chip_select_active_low_in, b_chip_select_active_high_in, b_read_write_select_in;
    logic b_output_enable_n_in, b_address_load_strobe_n_in, b_counter_advance_enable_n_in;
    logic b_counter_reload_n_in, b_output_latency_select_in;
    logic [3:0] a_byte_lane_enable_n_in, b_byte_lane_enable_n_in;
    logic [5:0] a_bank_select_in, b_bank_select_in;
    logic [11:0] a_word_addr_in, b_word_addr_in;
    logic [35:0] a_dq_in, a_dq_out, a_dq_oe_out, b_dq_in, b_dq_out, b_dq_oe_out;
    int errors = 0, num_checks = 0, cycles = 0;
    localparam logic [35:0] OLD = 36'hAAAAAAAAA, NEW = 36'h5A5A5A5A5;
    localparam logic [35:0] D1 = 36'h123456789, D2 = 36'h0FEDCBA98, D3 = 36'h9E3779B97;

    dpbs_top dpbs_top_i (.*);
    dpbs_host dpbs_host_a_i (.clk_in, .csl_out(a_chip_select_active_low_in),
        .csh_out(a_chip_select_active_high_in), .rw_out(a_read_write_select_in),
        .oen_out(a_output_enable_n_in), .be_out(a_byte_lane_enable_n_in),
        .bank_out(a_bank_select_in), .word_out(a_word_addr_in),
        .ads_out(a_address_load_strobe_n_in), .adv_out(a_counter_advance_enable_n_in),
        .rel_out(a_counter_reload_n_in), .lat_out(a_output_latency_select_in), .dq_out(a_dq_in));
    dpbs_host dpbs_host_b_i (.clk_in, .csl_out(b_chip_select_active_low_in),
        .csh_out(b_chip_select_active_high_in), .rw_out(b_read_write_select_in),
        .oen_out(b_output_enable_n_in), .be_out(b_byte_lane_enable_n_in),
        .bank_out(b_bank_select_in), .word_out(b_word_addr_in),
        .ads_out(b_address_load_strobe_n_in), .adv_out(b_counter_advance_enable_n_in),
        .rel_out(b_counter_reload_n_in), .lat_out(b_output_latency_select_in), .dq_out(b_dq_in));

    // 125 MHz clock and a cycle ceiling against hangs
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("[FAIL] %0t timeout", $time);
            print_verdict();
        end
    end

    // pins driven for a lane-enable pattern, active low enables
    function automatic logic [35:0] lanes(input logic [3:0] be_n);
        for (int i = 0; i < 4; i++) lanes[i*9 +: 9] = {9{~be_n[i]}};
    endfunction

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // sel is {active-low select, active-high select}, ctl is {load_n, advance_n, reload_n}
    task automatic req(input bit pb, input logic [1:0] sel, input logic rw, input logic [3:0] be,
                       input logic [17:0] ad, input logic [35:0] d, input logic [2:0] ctl);
        if (pb) dpbs_host_b_i.drive(sel, rw, be, ad, d, ctl);
        else dpbs_host_a_i.drive(sel, rw, be, ad, d, ctl);
    endtask

    task automatic wr(input bit pb, input logic [17:0] ad, input logic [3:0] be,
                      input logic [35:0] d);
        req(pb, 2'h1, 1'b0, be, ad, d, 3'h3);
    endtask

    // read with address load, then look at the output cycle that the latency gives
    task automatic rdchk(input bit pb, input logic [17:0] ad, input logic [3:0] be,
                         input logic [35:0] exp, input int lat);
        req(pb, 2'h1, 1'b1, be, ad, 36'h000000000, 3'h3);
        repeat (lat + 1) @(posedge clk_in);
        #1;
        chk(pb ? b_dq_oe_out : a_dq_oe_out, lanes(be));
        chk((pb ? b_dq_out : a_dq_out) & lanes(be), exp & lanes(be));
    endtask

    task automatic t_write_lanes();
        for (int p = 0; p < 16; p++) begin
            logic [35:0] merged;
            merged = (NEW & lanes(4'(p))) | (OLD & ~lanes(4'(p)));
            wr(0, {6'h01, 12'(p)}, 4'h0, OLD);
            wr(0, {6'h01, 12'(p)}, 4'(p), NEW);
            rdchk(0, {6'h01, 12'(p)}, 4'h0, merged, 0);
        end
    endtask

    task automatic t_read_lanes();
        for (int p = 0; p < 16; p++) rdchk(0, 18'h01000, 4'(p), NEW, 0);
        rdchk(0, 18'h01000, 4'h0, NEW, 0);
        // the read keeps standing, so every lane drives until output enable rises
        dpbs_host_a_i.mode(1'b1, 1'b0);
        #1;
        chk(a_dq_oe_out, 36'h000000000);
        dpbs_host_a_i.mode(1'b0, 1'b0);
        #1;
        chk(a_dq_oe_out, lanes(4'h0));
    endtask

    task automatic t_deselect();
        wr(0, 18'h02005, 4'h0, OLD);
        req(0, 2'h3, 1'b0, 4'h0, 18'h02005, NEW, 3'h3);
        req(0, 2'h0, 1'b0, 4'h0, 18'h02005, NEW, 3'h3);
        req(0, 2'h3, 1'b1, 4'h0, 18'h02005, NEW, 3'h3);
        @(posedge clk_in);
        #1;
        chk(a_dq_oe_out, 36'h000000000);
        rdchk(0, 18'h02005, 4'h0, OLD, 0);
    endtask

    // counter loads and advances while deselected, crossing banks and the top wrap
    task automatic t_counter();
        req(0, 2'h3, 1'b1, 4'hF, 18'h00FFF, OLD, 3'h3);
        req(0, 2'h1, 1'b0, 4'h0, 18'h3FFFF, D1, 3'h5);
        rdchk(0, 18'h01000, 4'h0, D1, 0);
        req(0, 2'h0, 1'b1, 4'hF, 18'h3FFFF, OLD, 3'h3);
        req(0, 2'h1, 1'b0, 4'h0, 18'h01234, D2, 3'h5);
        rdchk(0, 18'h00000, 4'h0, D2, 0);
        wr(0, 18'h03007, 4'h0, OLD);
        req(0, 2'h3, 1'b1, 4'hF, 18'h00000, OLD, 3'h5);
        req(0, 2'h3, 1'b1, 4'hF, 18'h00000, OLD, 3'h5);
        req(0, 2'h1, 1'b0, 4'h0, 18'h00000, D3, 3'h6);
        rdchk(0, 18'h03007, 4'h0, D3, 0);
        // a reload right after a strobe load returns to the address just loaded
        req(0, 2'h1, 1'b1, 4'h0, 18'h00000, OLD, 3'h6);
        @(posedge clk_in);
        #1;
        chk(a_dq_out, D3);
    endtask

    task automatic t_pipe();
        dpbs_host_b_i.mode(1'b0, 1'b1);
        req(1, 2'h3, 1'b1, 4'hF, 18'h00000, OLD, 3'h7);
        req(1, 2'h3, 1'b1, 4'hF, 18'h00000, OLD, 3'h7);
        req(1, 2'h1, 1'b1, 4'h0, 18'h01000, OLD, 3'h3);
        @(posedge clk_in);
        #1;
        chk(b_dq_oe_out, 36'h000000000);
        @(posedge clk_in);
        #1;
        chk(b_dq_out, D1);
        // latency select stays high one more edge so the delay check sees a whole access
        @(posedge clk_in);
        #1;
        chk(b_dq_oe_out, lanes(4'h0));
        dpbs_host_b_i.mode(1'b0, 1'b0);
    endtask

    // both ports busy in the same cycles, on different banks and then on one bank
    task automatic t_banks();
        fork
            wr(0, 18'h04001, 4'h0, D1);
            wr(1, 18'h05001, 4'h0, D2);
        join
        fork
            rdchk(0, 18'h05001, 4'h0, D2, 0);
            rdchk(1, 18'h04001, 4'h0, D1, 0);
        join
        // one bank on both ports: contents and read data are undefined, nothing is compared
        fork
            wr(0, 18'h06001, 4'h0, D3);
            wr(1, 18'h06002, 4'h0, D3);
        join
        fork
            req(0, 2'h1, 1'b1, 4'h0, 18'h06001, OLD, 3'h3);
            req(1, 2'h1, 1'b1, 4'h0, 18'h06002, OLD, 3'h3);
        join
        req(1, 2'h3, 1'b1, 4'hF, 18'h3F000, OLD, 3'h7);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(negedge clk_in);
        rstn_in <= 1'b1;
        chk(a_dq_oe_out | b_dq_oe_out, 36'h000000000);
        t_write_lanes();
        t_read_lanes();
        t_deselect();
        t_counter();
        t_pipe();
        t_banks();
        print_verdict();
    end
endmodule
